//--- fcs_params.svh
// constants for the clock frequency change sequencer: offsets, fields, resets, timing
// assumes a single 20 MHz command clock; figures are plain defaults, software may retune
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_CLK_PERIOD_NS 50
`define FCS_CYC(ns) (((ns) + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_T_CKSRE_NS 10
`define FCS_T_CKSRX_NS 10
`define FCS_T_XP_NS 24
`define FCS_T_XS_NS 170
`define FCS_T_MRD_NCK 4
`define FCS_T_DLLK_NCK 512
// register byte offsets
`define FCS_OFF_CTRL 8'h00
`define FCS_OFF_STATUS 8'h04
`define FCS_OFF_CKSRE 8'h08
`define FCS_OFF_CKSRX 8'h0C
`define FCS_OFF_XP 8'h10
`define FCS_OFF_XS 8'h14
`define FCS_OFF_MRD 8'h18
`define FCS_OFF_DLLK 8'h1C
`define FCS_OFF_MR0 8'h20
`define FCS_OFF_MR1 8'h24
`define FCS_OFF_MR2 8'h28
// control fields
`define FCS_CTRL_START 0
`define FCS_CTRL_PD 1
`define FCS_CTRL_DLL_ON 2
`define FCS_CTRL_MR2 3
`define FCS_CTRL_ODT_IDLE 4
`define FCS_CTRL_SEL_LO 8
`define FCS_CTRL_SEL_HI 11
// mode register address bits, mrs spacing and axi response codes
`define FCS_MR1_DLL_OFF_BIT 0
`define FCS_MR0_DLL_RST_BIT 8
`define FCS_MRS_MIN_GAP 4
`define FCS_RESP_OKAY 2'b00
`define FCS_RESP_SLVERR 2'b10
`endif

//--- fcs_pkg.sv
// types for the clock frequency change sequencer
// used by fcs_top, fcs_dram_model and the testbench; constants live in fcs_params.svh
package fcs_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_CKSRE, S_CHG, S_CKSRX, S_EXIT, S_MRS, S_GAP, S_DLLK
  } fcs_state_e;
  // dram command pins, active low
  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
  } fcs_cmd_s;
  // everything driven towards the dram
  typedef struct packed {
    logic cke;
    logic odt;
    fcs_cmd_s cmd;
    logic [2:0] ba;
    logic [14:0] addr;
  } fcs_pins_s;
endpackage : fcs_pkg

//--- fcs_top.sv
// clock frequency change sequencer for a ddr3 device: axi4-lite slave plus pin sequencer
// assumes clk is the dram command clock and a clock generator answers freq_req/clk_stable
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
module fcs_top #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output fcs_pkg::fcs_pins_s dram,
  output logic freq_req,
  output logic [3:0] freq_sel,
  input wire logic clk_stable
);
  fcs_pkg::fcs_state_e state_r;
  fcs_pkg::fcs_pins_s pins_r;
  logic [CW-1:0] t_cksre_r, t_cksrx_r, t_xp_r, t_xs_r, t_mrd_r, t_dllk_r;
  logic [15:0] mr0_r, mr1_r, mr2_r;
  logic pd_mode_r, dll_on_r, mr2_upd_r, odt_idle_r, start_r, done_r, err_r;
  logic [3:0] sel_r;
  logic freq_req_r, chg_low_r;
  logic [1:0] mrs_idx_r;
  logic [CW-1:0] cnt_r, dllk_cnt_r;
  logic stab_m_r, stab_s_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_mux;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic rd_hit, wr_fire, wr_hit;
  logic [CW-1:0] lim, mrd_eff;

  assign s_awready = awready_r;
  assign s_wready = wready_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = arready_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;
  assign dram = pins_r;
  assign freq_req = freq_req_r;
  assign freq_sel = sel_r;

  // clock generator status is asynchronous: two flops before use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stab_m_r <= 1'b0;
      stab_s_r <= 1'b0;
    end else begin
      stab_m_r <= clk_stable;
      stab_s_r <= stab_m_r;
    end
  end

  // write channel: address and data taken in either order, response after both
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `FCS_RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
    end else begin
      if (s_awvalid && awready_r) begin
        awready_r <= 1'b0;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r <= s_wdata;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
      end
      if (bvalid_r && s_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // write decode; status is read-only, byte strobes ignored (whole-word registers)
  assign wr_hit = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= `FCS_OFF_MR2)
    && (awaddr_r != `FCS_OFF_STATUS);

  // software registers: timing waits are programmable cycle counts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t_cksre_r <= CW'(`FCS_CYC(`FCS_T_CKSRE_NS));
      t_cksrx_r <= CW'(`FCS_CYC(`FCS_T_CKSRX_NS));
      t_xp_r <= CW'(`FCS_CYC(`FCS_T_XP_NS));
      t_xs_r <= CW'(`FCS_CYC(`FCS_T_XS_NS));
      t_mrd_r <= CW'(`FCS_T_MRD_NCK);
      t_dllk_r <= CW'(`FCS_T_DLLK_NCK);
      mr0_r <= 16'h0000;
      mr1_r <= 16'h0000;
      mr2_r <= 16'h0000;
      pd_mode_r <= 1'b0;
      dll_on_r <= 1'b0;
      mr2_upd_r <= 1'b0;
      odt_idle_r <= 1'b0;
      sel_r <= 4'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_fire && wr_hit) begin
        case (awaddr_r)
          `FCS_OFF_CTRL: begin
            if (state_r == fcs_pkg::S_IDLE) begin
              // settings frozen while a sequence runs
              pd_mode_r <= wdata_r[`FCS_CTRL_PD];
              dll_on_r <= wdata_r[`FCS_CTRL_DLL_ON];
              mr2_upd_r <= wdata_r[`FCS_CTRL_MR2];
              odt_idle_r <= wdata_r[`FCS_CTRL_ODT_IDLE];
              sel_r <= wdata_r[`FCS_CTRL_SEL_HI:`FCS_CTRL_SEL_LO];
            end
            start_r <= wdata_r[`FCS_CTRL_START];
          end
          `FCS_OFF_CKSRE: t_cksre_r <= wdata_r[CW-1:0];
          `FCS_OFF_CKSRX: t_cksrx_r <= wdata_r[CW-1:0];
          `FCS_OFF_XP: t_xp_r <= wdata_r[CW-1:0];
          `FCS_OFF_XS: t_xs_r <= wdata_r[CW-1:0];
          `FCS_OFF_MRD: t_mrd_r <= wdata_r[CW-1:0];
          `FCS_OFF_DLLK: t_dllk_r <= wdata_r[CW-1:0];
          `FCS_OFF_MR0: mr0_r <= wdata_r[15:0];
          `FCS_OFF_MR1: mr1_r <= wdata_r[15:0];
          `FCS_OFF_MR2: mr2_r <= wdata_r[15:0];
          default: start_r <= 1'b0;
        endcase
      end
    end
  end

  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_araddr)
      `FCS_OFF_CTRL: rd_mux = {20'h0_0000, sel_r, 3'b000, odt_idle_r, mr2_upd_r, dll_on_r,
        pd_mode_r, 1'b0};
      `FCS_OFF_STATUS: rd_mux = {20'h0_0000, 4'(state_r), 5'b0_0000, err_r, done_r,
        (state_r != fcs_pkg::S_IDLE)};
      `FCS_OFF_CKSRE: rd_mux = 32'(t_cksre_r);
      `FCS_OFF_CKSRX: rd_mux = 32'(t_cksrx_r);
      `FCS_OFF_XP: rd_mux = 32'(t_xp_r);
      `FCS_OFF_XS: rd_mux = 32'(t_xs_r);
      `FCS_OFF_MRD: rd_mux = 32'(t_mrd_r);
      `FCS_OFF_DLLK: rd_mux = 32'(t_dllk_r);
      `FCS_OFF_MR0: rd_mux = {16'h0000, mr0_r};
      `FCS_OFF_MR1: rd_mux = {16'h0000, mr1_r};
      `FCS_OFF_MR2: rd_mux = {16'h0000, mr2_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: data registered on the same edge that takes the address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `FCS_RESP_OKAY;
    end else if (s_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
    end else if (rvalid_r && s_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // wait limit of the current state, zero treated as one cycle
  assign mrd_eff = (t_mrd_r < CW'(`FCS_MRS_MIN_GAP)) ? CW'(`FCS_MRS_MIN_GAP) : t_mrd_r;
  always_comb begin
    case (state_r)
      fcs_pkg::S_CKSRE: lim = t_cksre_r;
      fcs_pkg::S_CKSRX: lim = t_cksrx_r;
      fcs_pkg::S_EXIT: lim = pd_mode_r ? t_xp_r : t_xs_r;
      fcs_pkg::S_GAP: lim = mrd_eff - CW'(1);
      default: lim = CW'(1);
    endcase
    if (lim == CW'(0)) begin
      lim = CW'(1);
    end
  end

  // sequencer: enter low-power state, swap clock, exit, relock dll
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= fcs_pkg::S_IDLE;
      pins_r <= {1'b1, 1'b0, 4'b1111, 3'b000, 15'h0000};
      freq_req_r <= 1'b0;
      chg_low_r <= 1'b0;
      cnt_r <= CW'(0);
      mrs_idx_r <= 2'd0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
      pins_r.cmd <= '{cs_b: 1'b0, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1};
      case (state_r)
        fcs_pkg::S_IDLE: begin
          pins_r.odt <= odt_idle_r;
          if (start_r) begin
            cnt_r <= CW'(0);
            pins_r.cke <= 1'b0;
            pins_r.odt <= 1'b0;
            state_r <= fcs_pkg::S_CKSRE;
            if (!pd_mode_r) begin
              pins_r.cmd <= '{cs_b: 1'b0, ras_b: 1'b0, cas_b: 1'b0, we_b: 1'b1};
            end
          end
        end
        fcs_pkg::S_CKSRE: if (cnt_r >= lim - CW'(1)) begin
          freq_req_r <= 1'b1;
          state_r <= fcs_pkg::S_CHG;
        end
        fcs_pkg::S_CHG: if (stab_s_r && chg_low_r) begin
          freq_req_r <= 1'b0;
          chg_low_r <= 1'b0;
          cnt_r <= CW'(0);
          state_r <= fcs_pkg::S_CKSRX;
        end else if (!stab_s_r) begin
          chg_low_r <= 1'b1; // old-clock stable flag still sits in the synchroniser
        end
        fcs_pkg::S_CKSRX: begin
          if (!stab_s_r) begin
            cnt_r <= CW'(0); // a glitching clock restarts the stable count
          end else if (cnt_r >= lim - CW'(1)) begin
            pins_r.cke <= 1'b1;
            cnt_r <= CW'(0);
            state_r <= fcs_pkg::S_EXIT;
          end
        end
        fcs_pkg::S_EXIT: if (cnt_r >= lim - CW'(1)) begin
          mrs_idx_r <= dll_on_r ? 2'd1 : 2'd0;
          state_r <= fcs_pkg::S_MRS;
        end
        fcs_pkg::S_MRS: begin
          pins_r.cmd <= '{cs_b: 1'b0, ras_b: 1'b0, cas_b: 1'b0, we_b: 1'b0};
          cnt_r <= CW'(0);
          state_r <= fcs_pkg::S_GAP;
          case (mrs_idx_r)
            2'd1: begin
              pins_r.ba <= 3'd1;
              pins_r.addr <= mr1_r[14:0] & ~15'h0001;
            end
            2'd2: begin
              pins_r.ba <= 3'd2;
              pins_r.addr <= mr2_r[14:0];
            end
            default: begin
              pins_r.ba <= 3'd0;
              pins_r.addr <= mr0_r[14:0] | 15'h0100;
            end
          endcase
        end
        fcs_pkg::S_GAP: if (cnt_r >= lim - CW'(1)) begin
          cnt_r <= CW'(0);
          if (mrs_idx_r == 2'd1) begin
            mrs_idx_r <= 2'd0;
            state_r <= fcs_pkg::S_MRS;
          end else if (mrs_idx_r == 2'd0 && mr2_upd_r) begin
            mrs_idx_r <= 2'd2;
            state_r <= fcs_pkg::S_MRS;
          end else begin
            state_r <= fcs_pkg::S_DLLK;
          end
        end
        fcs_pkg::S_DLLK: if (dllk_cnt_r >= t_dllk_r) begin
          state_r <= fcs_pkg::S_IDLE;
        end
        default: state_r <= fcs_pkg::S_IDLE;
      endcase
    end
  end
  // dll lock timer runs from the reset mrs, overlapping later mrs gaps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dllk_cnt_r <= CW'(0);
    end else if (state_r == fcs_pkg::S_MRS && mrs_idx_r == 2'd0) begin
      dllk_cnt_r <= CW'(1);
    end else if (dllk_cnt_r != '1) begin
      dllk_cnt_r <= dllk_cnt_r + CW'(1);
    end
  end
  // status flags: done set at the end, cleared by the next accepted start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (start_r && state_r == fcs_pkg::S_IDLE) begin
        done_r <= 1'b0;
        err_r <= 1'b0;
      end
      if (start_r && state_r != fcs_pkg::S_IDLE) begin
        err_r <= 1'b1;
      end
      if (state_r == fcs_pkg::S_DLLK && dllk_cnt_r >= t_dllk_r) begin
        done_r <= 1'b1;
      end
    end
  end
  // helper counters read only by the checks below
  logic [CW-1:0] cke_low_h, stab_h, exit_h;
  logic [7:0] mrs_gap_h;
  logic mrs_now;
  assign mrs_now = pins_r.cmd == 4'b0000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cke_low_h <= CW'(0);
      stab_h <= CW'(0);
      exit_h <= CW'(0);
      mrs_gap_h <= 8'hFF;
    end else begin
      cke_low_h <= pins_r.cke ? CW'(0) : cke_low_h + CW'(1);
      stab_h <= (state_r == fcs_pkg::S_CKSRX && stab_s_r) ? stab_h + CW'(1) : CW'(0);
      exit_h <= !pins_r.cke ? CW'(0) : (exit_h != '1) ? exit_h + CW'(1) : exit_h;
      mrs_gap_h <= mrs_now ? 8'd1 : (mrs_gap_h != 8'hFF) ? mrs_gap_h + 8'd1 : mrs_gap_h;
    end
  end
  sequence mrs_seen;
    pins_r.cmd == 4'b0000;
  endsequence
  sequence relock;
    state_r == fcs_pkg::S_DLLK;
  endsequence

  odt_low_seq_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_r != fcs_pkg::S_IDLE |-> !pins_r.odt) else $error("odt high during sequence");
  cke_low_chg_a: assert property (@(posedge clk) disable iff (!rst_b)
    freq_req_r |-> !pins_r.cke && !pins_r.odt) else $error("cke or odt high in change");
  cksre_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(freq_req_r) |-> cke_low_h >= t_cksre_r) else $error("clock change before tcksre");
  cksrx_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pins_r.cke) && state_r == fcs_pkg::S_EXIT |-> stab_h >= t_cksrx_r - CW'(1))
    else $error("cke rose before tcksrx");
  mrs_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    mrs_seen |-> mrs_gap_h >= 8'd4) else $error("mrs spacing under four");
  dll_reset_xp_a: assert property (@(posedge clk) disable iff (!rst_b)
    mrs_seen and pins_r.ba == 3'd0 |-> pins_r.addr[`FCS_MR0_DLL_RST_BIT] && exit_h > t_xp_r)
    else $error("dll reset bad");
  mr1_dll_on_a: assert property (@(posedge clk) disable iff (!rst_b)
    mrs_seen and pins_r.ba == 3'd1 |-> !pins_r.addr[`FCS_MR1_DLL_OFF_BIT])
    else $error("mr1 a0 set");
  relock_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
    relock |-> pins_r.cke && !pins_r.odt) else $error("pins wrong in relock");
  freq_only_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    freq_req_r |-> state_r == fcs_pkg::S_CHG ##1 !pins_r.cke)
    else $error("clock change outside low power");
  dllk_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    relock ##1 state_r == fcs_pkg::S_IDLE |-> done_r && dllk_cnt_r > t_dllk_r)
    else $error("relock ended early");
endmodule : fcs_top
`default_nettype wire

//--- fcs_dram_model.sv
// device-side model: ddr3 pin watcher plus the clock generator answering freq_req
// assumes it shares clk with fcs_top; counts cycles with any broken ordering into viol
`timescale 1ns/1ps
`default_nettype none
module fcs_dram_model #(
  parameter int T_CKSRE = 1,
  parameter int T_CKSRX = 1,
  parameter int T_XP = 1,
  parameter int T_XS = 4,
  parameter int T_DLLK = 512
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire fcs_pkg::fcs_pins_s dram,
  input wire logic freq_req,
  input wire logic [3:0] freq_sel,
  input wire logic slow,
  output logic clk_stable,
  output logic [7:0] viol,
  output logic [11:0] mrs_log,
  output logic [14:0] mr0_seen,
  output logic [14:0] mr1_seen,
  output logic [3:0] sel_seen,
  output logic sre_seen,
  output logic dll_locked
);
  logic cke_d, req_d, relock, bad;
  logic [7:0] lo_cnt, st_cnt, ex_cnt, gap_cnt, gen_cnt;
  logic [15:0] lk_cnt;
  wire logic mrs = dram.cmd == 4'h0;

  function automatic logic [7:0] sat(input logic [7:0] v);
    sat = (v == 8'hff) ? v : v + 8'h01;
  endfunction : sat

  // clock generator: slow mode mimics a long pll relock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_stable <= 1'b1;
      gen_cnt <= 8'h00;
      sel_seen <= 4'h0;
    end else if (freq_req && !req_d) begin
      clk_stable <= 1'b0;
      gen_cnt <= 8'h00;
      sel_seen <= freq_sel;
    end else if (!clk_stable) begin
      gen_cnt <= gen_cnt + 8'h01;
      clk_stable <= gen_cnt == (slow ? 8'h28 : 8'h03);
    end
  end

  // cycle counters in clock cycles, saturating so long idles never wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cke_d <= 1'b1;
      req_d <= 1'b0;
      lo_cnt <= 8'h00;
      st_cnt <= 8'h00;
      ex_cnt <= 8'hff;
      gap_cnt <= 8'hff;
    end else begin
      cke_d <= dram.cke;
      req_d <= freq_req;
      lo_cnt <= dram.cke ? 8'h00 : sat(lo_cnt);
      st_cnt <= clk_stable ? sat(st_cnt) : 8'h00;
      ex_cnt <= dram.cke ? sat(ex_cnt) : 8'h00;
      gap_cnt <= mrs ? 8'h01 : sat(gap_cnt);
    end
  end

  // pin checks; any cke-low entry is accepted, fast or slow exit alike
  always_comb begin
    bad = 1'b0;
    if (freq_req && !req_d && (dram.cke || lo_cnt < T_CKSRE)) bad = 1'b1;
    if ((freq_req || !clk_stable) && (dram.cke || dram.odt)) bad = 1'b1;
    if (dram.cke && !cke_d && (!clk_stable || st_cnt < T_CKSRX)) bad = 1'b1;
    if (mrs && (!dram.cke || gap_cnt < 4)) bad = 1'b1;
    if (mrs && ex_cnt < (sre_seen ? T_XS : T_XP)) bad = 1'b1;
    if (mrs && dram.ba == 3'h1 && dram.addr[0]) bad = 1'b1;
    if (mrs && dram.ba == 3'h0 && !dram.addr[8]) bad = 1'b1;
    if (relock && (!dram.cke || dram.odt)) bad = 1'b1;
  end

  // command log and dll lock; one cycle of slack left for the idle handoff
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      viol <= 8'h00;
      mrs_log <= 12'h000;
      mr0_seen <= 15'h0000;
      mr1_seen <= 15'h0000;
      sre_seen <= 1'b0;
      relock <= 1'b0;
      lk_cnt <= 16'h0000;
      dll_locked <= 1'b0;
    end else begin
      viol <= viol + {7'h00, bad};
      if (cke_d && !dram.cke) begin
        mrs_log <= 12'h000;
        sre_seen <= dram.cmd == 4'h1;
        dll_locked <= 1'b0;
      end else if (mrs) begin
        mrs_log <= {mrs_log[7:0], 1'b1, dram.ba};
      end
      if (mrs && dram.ba == 3'h1) mr1_seen <= dram.addr;
      if (mrs && dram.ba == 3'h0) begin
        mr0_seen <= dram.addr;
        relock <= 1'b1;
        lk_cnt <= 16'h0000;
      end else if (relock) begin
        lk_cnt <= lk_cnt + 16'h0001;
        if (lk_cnt == 16'(T_DLLK - 2)) begin
          relock <= 1'b0;
          dll_locked <= 1'b1;
        end
      end
    end
  end
endmodule : fcs_dram_model
`default_nettype wire

//--- fcs_top_tb_top.sv
// testbench for fcs_top: axi4-lite tasks, register checks, two frequency changes
// assumes fcs_dram_model stands at the pins and plays the clock generator
`timescale 1ns/1ps
`default_nettype none
`include "fcs_params.svh"
module fcs_top_tb_top;
  logic clk, rst_b, slow, freq_req, clk_stable, sre_seen, dll_locked;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr, viol;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb, freq_sel, sel_seen;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [11:0] mrs_log;
  logic [14:0] mr0_seen, mr1_seen;
  fcs_pkg::fcs_pins_s dram;
  int fails, samples_checked, cycles;
  localparam logic [31:0] DFLT [6] = '{`FCS_CYC(`FCS_T_CKSRE_NS), `FCS_CYC(`FCS_T_CKSRX_NS),
    `FCS_CYC(`FCS_T_XP_NS), `FCS_CYC(`FCS_T_XS_NS), `FCS_T_MRD_NCK, `FCS_T_DLLK_NCK};
  // mrd below four probes the minimum command spacing
  localparam logic [31:0] TV [6] = '{32'h3, 32'h2, 32'h2, 32'h4, 32'h2, 32'h14};

  fcs_top dut (
    .clk(clk), .rst_b(rst_b), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .dram(dram),
    .freq_req(freq_req), .freq_sel(freq_sel), .clk_stable(clk_stable));

  fcs_dram_model #(.T_CKSRE(3), .T_CKSRX(2), .T_XP(2), .T_XS(4), .T_DLLK(20)) mdl (
    .clk(clk), .rst_b(rst_b), .dram(dram), .freq_req(freq_req), .freq_sel(freq_sel),
    .slow(slow), .clk_stable(clk_stable), .viol(viol), .mrs_log(mrs_log),
    .mr0_seen(mr0_seen), .mr1_seen(mr1_seen), .sel_seen(sel_seen), .sre_seen(sre_seen),
    .dll_locked(dll_locked));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // leading edge keeps bready from being driven twice in one step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    rd = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_rd

  // one full change: start, refused restart, poll done, then model verdicts
  task automatic run(input logic [31:0] ctl, input logic [11:0] elog, input logic sre);
    int n;
    axi_wr(`FCS_OFF_CTRL, ctl);
    repeat (2) @(posedge clk);
    axi_rd(`FCS_OFF_STATUS);
    check("busy", rd[1:0], 32'h1);
    axi_wr(`FCS_OFF_CTRL, ctl);
    axi_rd(`FCS_OFF_STATUS);
    check("err", rd[2], 32'h1);
    n = 0;
    do begin
      axi_rd(`FCS_OFF_STATUS);
      n = n + 1;
    end while (rd[1] !== 1'b1 && n < 300);
    check("done", rd[1:0], 32'h2);
    check("viol", viol, 32'h0);
    check("mrs_log", mrs_log, elog);
    check("sre", sre_seen, sre);
    check("sel", sel_seen, ctl[11:8]);
    check("mr0", mr0_seen, 32'h0110);
    check("dll", dll_locked, 32'h1);
    $display("frequency change ctl %h finished", ctl);
  endtask : run

  initial begin
    rst_b = 1'b0;
    slow = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    check("cke_rst", dram.cke, 32'h1);
    check("req_rst", freq_req, 32'h0);
    check("rdy_rst", {s_awready, s_wready, s_arready}, 32'h7);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'h08 + 8'(4 * i));
      check("tdef", rd, DFLT[i]);
      axi_wr(8'h08 + 8'(4 * i), TV[i]);
      axi_rd(8'h08 + 8'(4 * i));
      check("tset", rd, TV[i]);
    end
    axi_rd(8'h40);
    check("unmap_d", rd, 32'h0);
    check("unmap_r", resp, `FCS_RESP_SLVERR);
    axi_wr(`FCS_OFF_STATUS, 32'h0000_0007);
    check("st_wr", resp, `FCS_RESP_SLVERR);
    axi_wr(8'h09, 32'h0000_0001);
    check("odd_wr", resp, `FCS_RESP_SLVERR);
    $display("register tests finished");
    axi_wr(`FCS_OFF_MR0, 32'h0000_0010);
    axi_wr(`FCS_OFF_MR1, 32'h0000_0045);
    axi_wr(`FCS_OFF_MR2, 32'h0000_0018);
    check("mr_wr", resp, `FCS_RESP_OKAY);
    axi_wr(`FCS_OFF_CTRL, 32'h0000_0010);
    repeat (2) @(posedge clk);
    check("odt_idle", dram.odt, 32'h1);
    // power-down change, dll stays on, termination enabled beforehand
    run(32'h0000_0513, 12'h008, 1'b0);
    slow <= 1'b1;
    // self-refresh change with dll switched on and mr2 update, slow relock
    run(32'h0000_0a0d, 12'h98a, 1'b1);
    check("mr1", mr1_seen, 32'h0044);
    test_done();
  end
endmodule : fcs_top_tb_top
`default_nettype wire
